//--- design/gsf_cfg.svh
// Offsets, field positions, reset values and mode codes of the pin block
`ifndef GSF_CFG_SVH
`define GSF_CFG_SVH

`define GSF_OFS_PIN_CONFIG 8'h33
`define GSF_OFS_STATUS 8'h40
`define GSF_OFS_FAULTS 8'h41
`define GSF_OFS_THIRD_CTRL 8'h42

`define GSF_CFG_ONE_HI 7
`define GSF_CFG_ONE_LO 6
`define GSF_CFG_TWO_HI 5
`define GSF_CFG_TWO_LO 4
`define GSF_CFG_THREE_HI 3
`define GSF_CFG_THREE_LO 2
`define GSF_CFG_TWO_OUT 1

`define GSF_ST_ONE 6
`define GSF_ST_TWO 5
`define GSF_ST_THREE 4
`define GSF_ST_ADC_BUSY 3
`define GSF_ST_ENERGY 2
`define GSF_ST_CHARGE 1
`define GSF_ST_TIME 0

`define GSF_FLT_RSVD 7
`define GSF_FLT_ONE 6
`define GSF_FLT_TWO 5
`define GSF_FLT_THREE 4
`define GSF_FLT_STUCK 3
`define GSF_FLT_ENERGY 2
`define GSF_FLT_CHARGE 1
`define GSF_FLT_TIME 0

`define GSF_CTL_ALERT 7
`define GSF_CTL_PULL 6

`define GSF_AL_ONE 6
`define GSF_AL_TWO 5
`define GSF_AL_STUCK 3
`define GSF_AL_ENERGY 2
`define GSF_AL_CHARGE 1
`define GSF_AL_TIME 0

`define GSF_MODE_IN_HIGH 2'h3
`define GSF_MODE_IN_LOW 2'h2
`define GSF_MODE_OUT_A 2'h1
`define GSF_MODE_OUT_B 2'h0

`define GSF_RST_PIN_CONFIG 8'h00
`define GSF_RST_FAULTS 8'h80
`define GSF_RST_THIRD_CTRL 8'h00

`endif

//--- design/gsf_pin_regs.sv
// Pin configuration, status, fault latching and third pin control
`timescale 1ns/10ps
`include "gsf_cfg.svh"
module gsf_pin_regs (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire gsf_pkg::gsf_addr_t reg_addr_i,
  input wire logic reg_wr_i,
  input wire gsf_pkg::gsf_byte_t reg_wdata_i,
  output gsf_pkg::gsf_byte_t reg_rdata_o,
  input wire logic pin_one_i,
  input wire logic pin_two_i,
  input wire logic pin_three_i,
  output logic pin_one_o,
  output logic pin_one_oe_o,
  output logic pin_two_o,
  output logic pin_two_oe_o,
  output logic pin_three_o,
  output logic pin_three_oe_o,
  output logic accumulate_gate_o,
  input wire logic adc_busy_i,
  input wire logic energy_ovf_i,
  input wire logic charge_ovf_i,
  input wire logic time_ovf_i,
  input wire logic stuck_wake_i,
  input wire logic stuck_wake_en_i,
  input wire logic alert_event_i,
  input wire gsf_pkg::gsf_byte_t alert_enable_bits_i
);
  import gsf_pkg::*;

  function automatic logic pin_active(input gsf_mode_t mode, input logic level);
    logic act;
    act = 1'b0;
    case (mode)
      `GSF_MODE_IN_HIGH: act = level;
      `GSF_MODE_IN_LOW: act = ~level;
      default: act = 1'b0;
    endcase
    return act;
  endfunction

  logic [2:0] pin_sync;
  logic one_lvl;
  logic two_lvl;
  logic three_lvl;

  gsf_byte_t pin_config_q;
  gsf_byte_t pin_config_d;
  gsf_byte_t fault_q;
  gsf_byte_t fault_d;
  gsf_byte_t third_ctrl_q;
  gsf_byte_t third_ctrl_d;
  gsf_byte_t status_q;
  gsf_byte_t status_d;
  gsf_byte_t rdata_q;
  gsf_byte_t rdata_d;
  logic one_oe_q;
  logic one_oe_d;
  logic two_oe_q;
  logic two_oe_d;
  logic three_oe_q;
  logic three_oe_d;
  logic gate_q;
  logic gate_d;
  logic drive_q;

  gsf_mode_t mode_one;
  gsf_mode_t mode_two;
  gsf_mode_t mode_three;
  logic wr_config;
  logic wr_fault;
  logic wr_ctrl;
  logic one_act;
  logic two_act;
  logic three_act;
  gsf_byte_t fault_set;
  logic alert_set;

  // Pins are asynchronous to the device clock
  gsf_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i({pin_three_i, pin_two_i, pin_one_i}),
    .sync_o(pin_sync)
  );

  assign one_lvl = pin_sync[0];
  assign two_lvl = pin_sync[1];
  assign three_lvl = pin_sync[2];

  assign mode_one = pin_config_q[`GSF_CFG_ONE_HI:`GSF_CFG_ONE_LO];
  assign mode_two = pin_config_q[`GSF_CFG_TWO_HI:`GSF_CFG_TWO_LO];
  assign mode_three = pin_config_q[`GSF_CFG_THREE_HI:`GSF_CFG_THREE_LO];

  assign wr_config = reg_wr_i && (reg_addr_i == `GSF_OFS_PIN_CONFIG);
  assign wr_fault = reg_wr_i && (reg_addr_i == `GSF_OFS_FAULTS);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == `GSF_OFS_THIRD_CTRL);

  assign one_act = pin_active(mode_one, one_lvl);
  assign two_act = pin_active(mode_two, two_lvl);
  assign three_act = pin_active(mode_three, three_lvl);

  // Configuration register; reserved bit 0 reads 0
  always_comb
  begin
    pin_config_d = pin_config_q;
    if (wr_config)
    begin
      pin_config_d = {reg_wdata_i[7:1], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      pin_config_q <= `GSF_RST_PIN_CONFIG;
    end
    else
    begin
      pin_config_q <= pin_config_d;
    end
  end

  // Sticky faults and alert bit; a set in the clearing cycle wins
  always_comb
  begin
    fault_set = 8'h00;
    fault_set[`GSF_FLT_ONE] = one_act;
    fault_set[`GSF_FLT_TWO] = two_act;
    fault_set[`GSF_FLT_THREE] = three_act;
    fault_set[`GSF_FLT_STUCK] = stuck_wake_i && stuck_wake_en_i;
    fault_set[`GSF_FLT_ENERGY] = energy_ovf_i;
    fault_set[`GSF_FLT_CHARGE] = charge_ovf_i;
    fault_set[`GSF_FLT_TIME] = time_ovf_i;
    alert_set = alert_event_i
      || (fault_set[`GSF_FLT_ONE] && alert_enable_bits_i[`GSF_AL_ONE])
      || (fault_set[`GSF_FLT_TWO] && alert_enable_bits_i[`GSF_AL_TWO])
      || (fault_set[`GSF_FLT_STUCK] && alert_enable_bits_i[`GSF_AL_STUCK])
      || (fault_set[`GSF_FLT_ENERGY] && alert_enable_bits_i[`GSF_AL_ENERGY])
      || (fault_set[`GSF_FLT_CHARGE] && alert_enable_bits_i[`GSF_AL_CHARGE])
      || (fault_set[`GSF_FLT_TIME] && alert_enable_bits_i[`GSF_AL_TIME]);
    fault_d = fault_q;
    if (wr_fault)
    begin
      fault_d = fault_q & reg_wdata_i;
    end
    fault_d = fault_d | fault_set;
    fault_d[`GSF_FLT_RSVD] = 1'b1;
    third_ctrl_d = third_ctrl_q;
    if (wr_ctrl)
    begin
      third_ctrl_d = {reg_wdata_i[7:6], 6'h00};
    end
    if (alert_set)
    begin
      third_ctrl_d[`GSF_CTL_ALERT] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      fault_q <= `GSF_RST_FAULTS;
      third_ctrl_q <= `GSF_RST_THIRD_CTRL;
    end
    else
    begin
      fault_q <= fault_d;
      third_ctrl_q <= third_ctrl_d;
    end
  end

  // Live status, pin drivers and read data
  always_comb
  begin
    status_d = 8'h00;
    status_d[`GSF_ST_ONE] = one_act;
    status_d[`GSF_ST_TWO] = (mode_two == `GSF_MODE_OUT_B) ? two_lvl : two_act;
    status_d[`GSF_ST_THREE] = three_act;
    status_d[`GSF_ST_ADC_BUSY] = adc_busy_i;
    status_d[`GSF_ST_ENERGY] = energy_ovf_i;
    status_d[`GSF_ST_CHARGE] = charge_ovf_i;
    status_d[`GSF_ST_TIME] = time_ovf_i;
    one_oe_d = (mode_one == `GSF_MODE_OUT_B);
    two_oe_d = (mode_two == `GSF_MODE_OUT_A) && pin_config_q[`GSF_CFG_TWO_OUT];
    three_oe_d = ((mode_three == `GSF_MODE_OUT_B) && third_ctrl_q[`GSF_CTL_ALERT])
      || ((mode_three == `GSF_MODE_OUT_A) && third_ctrl_q[`GSF_CTL_PULL]);
    gate_d = (mode_two == `GSF_MODE_OUT_B) && two_lvl;
    case (reg_addr_i)
      `GSF_OFS_PIN_CONFIG: rdata_d = pin_config_q;
      `GSF_OFS_STATUS: rdata_d = status_q;
      `GSF_OFS_FAULTS: rdata_d = fault_q;
      `GSF_OFS_THIRD_CTRL: rdata_d = third_ctrl_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      status_q <= 8'h00;
      rdata_q <= 8'h00;
      one_oe_q <= 1'b0;
      two_oe_q <= 1'b0;
      three_oe_q <= 1'b0;
      gate_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      rdata_q <= rdata_d;
      one_oe_q <= one_oe_d;
      two_oe_q <= two_oe_d;
      three_oe_q <= three_oe_d;
      gate_q <= gate_d;
      drive_q <= 1'b0;
    end
  end

  // Open-drain pins only ever drive low
  assign pin_one_o = drive_q;
  assign pin_two_o = drive_q;
  assign pin_three_o = drive_q;
  assign pin_one_oe_o = one_oe_q;
  assign pin_two_oe_o = two_oe_q;
  assign pin_three_oe_o = three_oe_q;
  assign accumulate_gate_o = gate_q;
  assign reg_rdata_o = rdata_q;

  default clocking clk_blk @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  a_pin_one_low: assert property (
    (mode_one == `GSF_MODE_OUT_B) |=> pin_one_oe_o
  ) else $error("first pin not pulled low in drive-low mode");

  a_pin_one_hiz: assert property (
    (mode_one != `GSF_MODE_OUT_B) |=> !pin_one_oe_o
  ) else $error("first pin driven outside drive-low mode");

  a_pin_two_out: assert property (
    (mode_two == `GSF_MODE_OUT_A) |=> (pin_two_oe_o == $past(pin_config_q[1]))
  ) else $error("second pin does not follow its output bit");

  a_pin_three_alert: assert property (
    (mode_three == `GSF_MODE_OUT_B) |=> (pin_three_oe_o == $past(third_ctrl_q[7]))
  ) else $error("third pin does not follow the alert bit");

  a_pin_three_pull: assert property (
    (mode_three == `GSF_MODE_OUT_A) |=> (pin_three_oe_o == $past(third_ctrl_q[6]))
  ) else $error("third pin does not follow the pull-down bit");

  a_pin_three_input: assert property (
    mode_three[1] |=> !pin_three_oe_o
  ) else $error("third pin driven in an input mode");

  a_fault_pin_one: assert property (
    ((mode_one == `GSF_MODE_IN_LOW) && !one_lvl) |=> fault_q[6]
  ) else $error("first pin fault not latched");

  a_status_pin_one: assert property (
    ((mode_one == `GSF_MODE_IN_HIGH) && one_lvl) |=> status_q[6] ##1 reg_rdata_o[6]
      || $past(reg_addr_i) != `GSF_OFS_STATUS
  ) else $error("first pin state not reported");

  a_status_raw: assert property (
    (mode_two == `GSF_MODE_OUT_B) |=> (status_q[5] == $past(two_lvl))
  ) else $error("second pin raw level not reported");

  a_fault_stuck: assert property (
    (stuck_wake_i && stuck_wake_en_i) |=> fault_q[3]
  ) else $error("stuck-bus wake fault not latched");

  a_fault_ovf: assert property (
    (energy_ovf_i && charge_ovf_i && time_ovf_i) |=> (fault_q[2:0] == 3'h7) && fault_q[7]
  ) else $error("overflow faults not latched");

  a_fault_sticky: assert property (
    (fault_q[5] && !(wr_fault && !reg_wdata_i[5])) |=> fault_q[5]
  ) else $error("fault bit lost without a clearing write");

  a_alert_set: assert property (
    alert_event_i |=> third_ctrl_q[7] [*2] or (third_ctrl_q[7] ##1 $past(wr_ctrl))
  ) else $error("alert bit not set by an alert");

  a_alert_gate: assert property (
    (!alert_event_i && (alert_enable_bits_i == 8'h00) && !wr_ctrl && !third_ctrl_q[7])
      |=> !third_ctrl_q[7]
  ) else $error("alert bit set without an enabled cause");

  a_status_ovf: assert property (
    $rose(charge_ovf_i) |=> status_q[1] ##1 (reg_rdata_o[1] || $past(reg_addr_i) != 8'h40)
  ) else $error("charge overflow not shown in status");

  a_gate_follow: assert property (
    (mode_two == `GSF_MODE_OUT_B) |=> (accumulate_gate_o == $past(two_lvl))
  ) else $error("accumulate gate does not follow the second pin");

  a_gate_idle: assert property (
    (mode_two != `GSF_MODE_OUT_B) |=> !accumulate_gate_o
  ) else $error("accumulate gate open outside accumulate mode");

  a_status_busy: assert property (
    adc_busy_i |=> status_q[`GSF_ST_ADC_BUSY]
  ) else $error("converter busy not shown in status");

  a_status_pin_three: assert property (
    !mode_three[1] |=> !status_q[`GSF_ST_THREE]
  ) else $error("third pin state set outside input modes");

  a_fault_pin_two: assert property (
    ((mode_two == `GSF_MODE_IN_HIGH) && two_lvl) |=> fault_q[`GSF_FLT_TWO]
  ) else $error("second pin fault not latched");

  a_reserved_bits: assert property (
    fault_q[`GSF_FLT_RSVD] && (third_ctrl_q[5:0] == 6'h00) && !pin_config_q[0]
  ) else $error("reserved bits do not read their fixed values");

endmodule

//--- design/gsf_pkg.sv
// Types shared by the pin block files
package gsf_pkg;
  typedef logic [7:0] gsf_byte_t;
  typedef logic [7:0] gsf_addr_t;
  typedef logic [1:0] gsf_mode_t;
endpackage

//--- design/gsf_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module gsf_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

//--- tb/gsf_host_model.sv
// Register host model driving the byte port of the pin block
`timescale 1ns/10ps
module gsf_host_model (
  input wire logic sys_clk_i,
  output gsf_pkg::gsf_addr_t reg_addr_o,
  output logic reg_wr_o,
  output gsf_pkg::gsf_byte_t reg_wdata_o,
  input wire gsf_pkg::gsf_byte_t reg_rdata_i
);
  import gsf_pkg::*;
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // One-cycle strobe; sticky bits are only cleared by writing 0
  task automatic wr(input gsf_addr_t a, input gsf_byte_t d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  // Read data lands one edge after the address
  task automatic rd(input gsf_addr_t a, output gsf_byte_t d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    @(negedge sys_clk_i);
    d = reg_rdata_i;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the pin configuration and fault block
`timescale 1ns/10ps
`include "gsf_cfg.svh"
module tb;
  import gsf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  gsf_addr_t addr;
  logic wr;
  gsf_byte_t wdata, rdata, rv, m;
  logic [2:0] ext = 3'h0;
  wire [2:0] oe;
  wire [2:0] pv;
  logic [2:0] act;
  logic gate, busy = 1'b0, e_ovf = 1'b0, c_ovf = 1'b0, t_ovf = 1'b0;
  logic stuck = 1'b0, stuck_en = 1'b0, alert_ev = 1'b0;
  gsf_byte_t al_en = 8'h00;
  gsf_byte_t cfg_t [8] = '{8'h40, 8'h52, 8'h50, 8'h44, 8'h44, 8'h40, 8'h40, 8'h44};
  gsf_byte_t ctl_t [8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h40, 8'hC0, 8'h80};
  logic [2:0] oe_t [8] = '{3'h0, 3'h2, 3'h0, 3'h4, 3'h0, 3'h0, 3'h4, 3'h0};
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  gsf_host_model gsf_host_model_i (.sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));
  // Open-drain pins with pull-ups: ext low means the outside pulls low
  gsf_pin_regs gsf_pin_regs_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .pin_one_i(ext[0] & ~oe[0]), .pin_two_i(ext[1] & ~oe[1]), .pin_three_i(ext[2] & ~oe[2]),
    .pin_one_o(pv[0]), .pin_one_oe_o(oe[0]), .pin_two_o(pv[1]), .pin_two_oe_o(oe[1]),
    .pin_three_o(pv[2]), .pin_three_oe_o(oe[2]), .accumulate_gate_o(gate),
    .adc_busy_i(busy), .energy_ovf_i(e_ovf), .charge_ovf_i(c_ovf), .time_ovf_i(t_ovf),
    .stuck_wake_i(stuck), .stuck_wake_en_i(stuck_en), .alert_event_i(alert_ev),
    .alert_enable_bits_i(al_en));
  task automatic chk(input string nm, input gsf_byte_t seen, input gsf_byte_t exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input string nm, input gsf_addr_t a, input gsf_byte_t exp);
    gsf_host_model_i.rd(a, rv);
    chk(nm, rv, exp);
  endtask
  task automatic put(input gsf_addr_t a, input gsf_byte_t d);
    gsf_host_model_i.wr(a, d);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  initial
  begin
    w(6);
    reset_i = 1'b0;
    rchk("cfg", `GSF_OFS_PIN_CONFIG, `GSF_RST_PIN_CONFIG);
    rchk("flt", `GSF_OFS_FAULTS, `GSF_RST_FAULTS);
    rchk("ctl", `GSF_OFS_THIRD_CTRL, `GSF_RST_THIRD_CTRL);
    rchk("sts", `GSF_OFS_STATUS, 8'h00);
    rchk("unmapped", 8'h50, 8'h00);
    chk("oe", {5'h00, oe}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      put(`GSF_OFS_PIN_CONFIG, cfg_t[i]);
      put(`GSF_OFS_THIRD_CTRL, ctl_t[i]);
      w(1);
      chk("oe", {5'h00, oe}, {5'h00, oe_t[i]});
      chk("level", {5'h00, pv}, 8'h00);
      rchk("ctl", `GSF_OFS_THIRD_CTRL, ctl_t[i]);
    end
    put(`GSF_OFS_THIRD_CTRL, 8'h00);
    rchk("ctl", `GSF_OFS_THIRD_CTRL, 8'h00);
    put(`GSF_OFS_PIN_CONFIG, 8'hFF);
    put(`GSF_OFS_STATUS, 8'hFF);
    rchk("cfg", `GSF_OFS_PIN_CONFIG, 8'hFE);
    rchk("sts", `GSF_OFS_STATUS, 8'h00);
    // Active high then active low inputs on all three pins
    for (int j = 0; j < 2; j++)
    begin
      m = j ? 8'hA8 : 8'hFC;
      ext = j ? 3'h7 : 3'h0;
      put(`GSF_OFS_PIN_CONFIG, m);
      w(4);
      put(`GSF_OFS_FAULTS, 8'h00);
      rchk("flt", `GSF_OFS_FAULTS, 8'h80);
      ext[0] = ~ext[0];
      w(4);
      ext[0] = ~ext[0];
      w(4);
      rchk("flt", `GSF_OFS_FAULTS, 8'hC0);
      for (int v = 0; v < 8; v++)
      begin
        ext = v[2:0];
        act = j ? ~ext : ext;
        w(4);
        rchk("sts", `GSF_OFS_STATUS, {1'b0, act[0], act[1], act[2], 4'h0});
      end
      rchk("flt", `GSF_OFS_FAULTS, 8'hF0);
    end
    put(`GSF_OFS_PIN_CONFIG, 8'h00);
    ext = 3'h6;
    w(4);
    put(`GSF_OFS_FAULTS, 8'h00);
    rchk("sts", `GSF_OFS_STATUS, 8'h20);
    chk("gate", {7'h00, gate}, 8'h01);
    rchk("flt", `GSF_OFS_FAULTS, 8'h80);
    {busy, e_ovf, c_ovf, t_ovf, stuck} = 5'h1F;
    w(2);
    rchk("sts", `GSF_OFS_STATUS, 8'h2F);
    {busy, e_ovf, c_ovf, t_ovf, stuck} = 5'h00;
    w(1);
    rchk("sts", `GSF_OFS_STATUS, 8'h20);
    rchk("flt", `GSF_OFS_FAULTS, 8'h87);
    rchk("ctl", `GSF_OFS_THIRD_CTRL, 8'h00);
    stuck_en = 1'b1;
    stuck = 1'b1;
    w(1);
    stuck = 1'b0;
    rchk("flt", `GSF_OFS_FAULTS, 8'h8F);
    put(`GSF_OFS_FAULTS, 8'h00);
    al_en = 8'h04;
    e_ovf = 1'b1;
    w(1);
    e_ovf = 1'b0;
    rchk("ctl", `GSF_OFS_THIRD_CTRL, 8'h80);
    put(`GSF_OFS_FAULTS, 8'h00);
    put(`GSF_OFS_THIRD_CTRL, 8'h00);
    rchk("ctl", `GSF_OFS_THIRD_CTRL, 8'h00);
    alert_ev = 1'b1;
    w(1);
    alert_ev = 1'b0;
    rchk("ctl", `GSF_OFS_THIRD_CTRL, 8'h80);
    test_done;
  end
endmodule
